/* dv/cso_contacts.sv */
`timescale 1ns/100ps
// contact bank: force on terminal 0, offset on terminal 1
module cso_contacts (
    input  wire logic       i_core_clk,
    input  wire logic       i_force,
    input  wire logic       i_offset,
    output logic      [5:0] o_terminals
);
    initial o_terminals = 6'h00;
    // unassigned contacts chatter, so stray terminals must be ignored
    always @(posedge i_core_clk) begin
        o_terminals <= {4'($urandom), i_offset, i_force};
    end
endmodule

/* dv/cso_properties.sv */
`timescale 1ns/100ps
// override handshake watcher on the top ports
module cso_properties
    import cso_pkg::*;
(
    input wire logic         i_core_clk,
    input wire logic         i_srst,
    input wire logic         i_avs_read,
    input wire logic         i_avs_write,
    input wire logic         o_avs_waitrequest,
    input wire cso_run_cmd_t i_keypad_run,
    input wire logic         i_motor_driving,
    input wire cso_run_cmd_t o_run_cmd,
    input wire logic         o_force_stop,
    input wire logic         o_keypad_active
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    // one wait state per access, none when idle
    bus_wait_a: assert property ((i_avs_read || i_avs_write) &&
        o_avs_waitrequest |=> !o_avs_waitrequest) else $error("answer late");
    idle_wait_a: assert property (!(i_avs_read || i_avs_write) |->
        !o_avs_waitrequest) else $error("wait while idle");
    // stop phase of a source change under load
    stop_cmd_a: assert property (o_force_stop |->
        !o_run_cmd.start && o_run_cmd.stop) else $error("no stop command");
    stop_start_a: assert property ($rose(o_force_stop) |->
        $past(i_motor_driving, 2)) else $error("stop without load");
    stop_end_a: assert property ($fell(o_force_stop) |->
        !$past(i_motor_driving, 2)) else $error("stop left early");
    stop_hold_a: assert property (o_force_stop &&
        $past(i_motor_driving) |=> o_force_stop)
        else $error("stop dropped under load");
    switch_idle_a: assert property ($changed(o_keypad_active) |->
        !$past(i_motor_driving)) else $error("switched under load");
    // settled keypad override passes keypad run requests
    keypad_run_a: assert property (o_keypad_active[*3] ##0
        !o_force_stop && !i_motor_driving && !$past(i_motor_driving)
        |=> o_run_cmd == $past(i_keypad_run))
        else $error("keypad run ignored");
    cover property ($rose(o_force_stop));
    cover property ($rose(o_keypad_active));
    cover property (i_avs_write && !o_avs_waitrequest);
endmodule

bind cso_top cso_properties chk_u (
    .i_core_clk       (i_core_clk),
    .i_srst           (i_srst),
    .i_avs_read       (i_avs_read),
    .i_avs_write      (i_avs_write),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_keypad_run     (i_keypad_run),
    .i_motor_driving  (i_motor_driving),
    .o_run_cmd        (o_run_cmd),
    .o_force_stop     (o_force_stop),
    .o_keypad_active  (o_keypad_active)
);

/* dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import cso_pkg::*;
    localparam logic [15:0] OFS = 16'h0100;
    localparam logic [15:0] MX  = 16'h1000;
    logic           clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic           drv = 1'b0, f_on = 1'b0, o_on = 1'b0, wq, fs, ka, dir;
    logic [3:0]     adr = 4'h0;
    logic [31:0]    wd = 32'h0, rdat, q;
    logic [5:0]     term;
    logic [2:0]     fsel;
    logic [15:0]    fq;
    cso_setpoints_t sp = '0;
    cso_run_cmd_t   kr = '0, er = '0, run;
    int             mismatches = 0, total_checks = 0, cyc = 0;

    always #12.5 clk = ~clk;

    cso_contacts ct_u (.i_core_clk(clk), .i_force(f_on), .i_offset(o_on),
        .o_terminals(term));
    cso_top dut_u (.i_core_clk(clk), .i_srst(srst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq), .i_terminals(term), .i_setpoints(sp),
        .i_keypad_run(kr), .i_ext_run(er), .i_motor_driving(drv),
        .o_freq_cmd(fq), .o_run_cmd(run), .o_force_stop(fs),
        .o_keypad_active(ka));

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hold the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        rd <= !w; wr <= w; adr <= a; wd <= d;
        do @(posedge clk); while (wq !== 1'b0);
        q = rdat;
        rd <= 1'b0; wr <= 1'b0;
    endtask

    // selected setpoint, offset applied, clamped to zero..max
    function automatic logic [15:0] expf(input logic [2:0] s, input logic k);
        logic [16:0] b;
        case (k ? 3'h0 : s)
            3'h0: b = {1'b0, sp.src0};
            3'h1: b = {1'b0, sp.src1};
            3'h2: b = {1'b0, sp.src2};
            3'h3: b = {1'b0, sp.src3};
            default: b = {1'b0, sp.src4};
        endcase
        if (o_on && !dir) b = b + OFS;
        if (o_on && dir) b = (b < OFS) ? 17'h0 : b - OFS;
        return (b > MX) ? MX : b[15:0];
    endfunction

    // hang guard, far above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(13314));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        bus(1'b0, 4'h8, 32'h0); chk("src reset", q, 32'h0);
        bus(1'b0, 4'hc, 32'h0); chk("freq reset", q, 32'hffff0000);
        bus(1'b0, 4'h2, 32'h0); chk("unmapped", q, 32'h0);
        bus(1'b1, 4'h0, 32'h0000321f);
        bus(1'b1, 4'hc, {MX, OFS});
        bus(1'b0, 4'hc, 32'h0); chk("freq reg", q, {MX, OFS});
        // random sources, contacts, setpoints; motor idle
        for (int i = 0; i < 40; i++) begin
            fsel = (i < 5) ? 3'(i) : 3'($urandom_range(0, 4));
            dir = 1'($urandom);
            bus(1'b1, 4'h8, {23'h0, dir, 2'h0, 2'h1, 1'b0, fsel});
            @(posedge clk);
            for (int j = 0; j < 5; j++)
                sp[j*16 +: 16] <= 16'($urandom_range(0, 'h11ff));
            kr <= 2'($urandom); er <= 2'($urandom);
            f_on <= (i < 5) ? 1'b0 : 1'($urandom);
            o_on <= 1'($urandom);
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk("keypad", ka, f_on);
            chk("freq", fq, expf(fsel, f_on));
            chk("run", run, f_on ? kr : er);
        end
        // force change under load: stop first, switch after
        // settle keypad off with the motor idle before loading it
        @(posedge clk); f_on <= 1'b0;
        repeat (4) @(posedge clk);
        drv <= 1'b1;
        repeat (4) @(posedge clk);
        f_on <= 1'b1;
        repeat (4) @(negedge clk);
        chk("stop", fs, 1'b1);
        chk("stop run", run, 2'b01);
        chk("held", ka, 1'b0);
        @(posedge clk); drv <= 1'b0;
        repeat (4) @(negedge clk);
        chk("stop off", fs, 1'b0);
        chk("switched", ka, 1'b1);
        end_sim();
    end
endmodule

/* hw/cso_offset_calc.sv */
`timescale 1ns/100ps
// offset add/subtract with saturation, registered result
module cso_offset_calc
    import cso_pkg::*;
(
    input  wire logic                  i_core_clk,
    input  wire logic                  i_srst,
    input  wire logic [CSO_FREQ_W-1:0] i_base,
    input  wire logic [CSO_FREQ_W-1:0] i_offset,
    input  wire logic [CSO_FREQ_W-1:0] i_fmax,
    input  wire logic                  i_apply,
    input  wire logic                  i_subtract,
    output logic      [CSO_FREQ_W-1:0] o_freq
);
    logic [CSO_FREQ_W:0]   sum;
    logic [CSO_FREQ_W-1:0] res_nxt;

    // widened sum keeps the carry so overflow can be clamped
    always_comb begin
        sum = {1'b0, i_base} + {1'b0, i_offset};
        res_nxt = i_base;
        if (i_apply) begin
            if (i_subtract) begin
                res_nxt = (i_offset > i_base) ? CSO_ZERO_HZ
                          : i_base - i_offset;
            end else begin
                res_nxt = sum[CSO_FREQ_W-1:0];
            end
        end
        if (sum[CSO_FREQ_W] && i_apply && !i_subtract) begin
            res_nxt = i_fmax;
        end else if (res_nxt > i_fmax) begin
            res_nxt = i_fmax;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_freq <= CSO_ZERO_HZ;
        end else begin
            o_freq <= res_nxt;
        end
    end
endmodule

/* hw/cso_pkg.sv */
// Summary of operation
// - input with function code 31 forces keypad as frequency and run source
// - while forced, keypad start, stop and speed act at once
// - when released, configured frequency and run sources return
// - force change while driving: stop motor first, then switch sources
// - input with function code 50 applies stored offset to setpoint
// - direction setting chooses add or subtract of the offset
// - offset only while offset input is on; else setpoint passes, limited to max frequency
// - offset works with any of the five frequency sources, in real time
package cso_pkg;
    localparam int          CSO_FREQ_W     = 16;
    localparam int          CSO_NUM_INPUTS = 6;
    localparam int          CSO_NUM_SRC    = 5;
    localparam logic [7:0]  CSO_FN_FORCE   = 8'h1f;   // function code 31
    localparam logic [7:0]  CSO_FN_OFFSET  = 8'h32;   // function code 50
    localparam logic [2:0]  CSO_SRC_KEYPAD = 3'h0;
    localparam logic [1:0]  CSO_RUN_KEYPAD = 2'h0;
    localparam logic [15:0] CSO_ZERO_HZ    = 16'h0000;
    localparam logic [15:0] CSO_FMAX_RST   = 16'hffff;

    // register offsets (byte addresses)
    localparam logic [3:0] CSO_A_FUNC_LO = 4'h0;  // inputs 0..3 function codes
    localparam logic [3:0] CSO_A_FUNC_HI = 4'h4;  // inputs 4..5 function codes
    localparam logic [3:0] CSO_A_SRC     = 4'h8;  // source selects, offset dir
    localparam logic [3:0] CSO_A_FREQ    = 4'hc;  // offset value, max frequency

    typedef enum logic [1:0] {
        CSO_ST_IDLE = 2'b00,
        CSO_ST_STOP = 2'b01
    } cso_state_t;

    // per-source setpoint bundle
    typedef struct packed {
        logic [CSO_FREQ_W-1:0] src0;
        logic [CSO_FREQ_W-1:0] src1;
        logic [CSO_FREQ_W-1:0] src2;
        logic [CSO_FREQ_W-1:0] src3;
        logic [CSO_FREQ_W-1:0] src4;
    } cso_setpoints_t;

    // run requests from the keypad and the external run source
    typedef struct packed {
        logic start;
        logic stop;
    } cso_run_cmd_t;
endpackage

/* hw/cso_top.sv */
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
// command source override and frequency offset
module cso_top
    import cso_pkg::*;
(
    input  wire logic                  i_core_clk,
    input  wire logic                  i_srst,
    // avalon-mm slave
    input  wire logic [3:0]            i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [31:0]           i_avs_writedata,
    input  wire logic [3:0]            i_avs_byteenable,
    output logic      [31:0]           o_avs_readdata,
    output logic                       o_avs_waitrequest,
    // intelligent input terminals
    input  wire logic [CSO_NUM_INPUTS-1:0] i_terminals,
    // frequency sources and run commands
    input  wire cso_setpoints_t        i_setpoints,
    input  wire cso_run_cmd_t          i_keypad_run,
    input  wire cso_run_cmd_t          i_ext_run,
    input  wire logic                  i_motor_driving,
    // outputs to drive core
    output logic      [CSO_FREQ_W-1:0] o_freq_cmd,
    output cso_run_cmd_t               o_run_cmd,
    output logic                       o_force_stop,
    output logic                       o_keypad_active
);
    logic [7:0]            func_r [CSO_NUM_INPUTS];
    logic [2:0]            frequency_source_select_r;
    logic [1:0]            run_source_select_r;
    logic                  offset_direction_select_r;
    logic [CSO_FREQ_W-1:0] offset_frequency_value_r;
    logic [CSO_FREQ_W-1:0] max_freq_r;
    logic                  ack_r;
    cso_state_t            state_r;
    logic                  keypad_r;
    logic                  operator_force_input;
    logic                  offset_input;
    logic [2:0]            eff_fsrc;
    logic [CSO_FREQ_W-1:0] base_freq;

    // true when any terminal carries the given function and is on
    function automatic logic fn_active(input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < CSO_NUM_INPUTS; k++) begin
            if (func_r[k] == code && i_terminals[k]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic [7:0] merge8(input logic [7:0] old,
                                          input logic [7:0] nw,
                                          input logic       en);
        return en ? nw : old;
    endfunction

    assign operator_force_input = fn_active(CSO_FN_FORCE);
    assign offset_input         = fn_active(CSO_FN_OFFSET);

    // one wait state: ack rises the cycle after the request
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (i_avs_read || i_avs_write) && !ack_r;
        end
    end

    // register writes take effect on the acknowledging edge
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            for (int k = 0; k < CSO_NUM_INPUTS; k++) begin
                func_r[k] <= 8'h00;
            end
            frequency_source_select_r <= 3'h0;
            run_source_select_r       <= 2'h0;
            offset_direction_select_r <= 1'b0;
            offset_frequency_value_r  <= CSO_ZERO_HZ;
            max_freq_r                <= CSO_FMAX_RST;
        end else if (i_avs_write && ack_r) begin
            case (i_avs_address)
                CSO_A_FUNC_LO: begin
                    for (int k = 0; k < 4; k++) begin
                        func_r[k] <= merge8(func_r[k],
                            i_avs_writedata[k*8 +: 8], i_avs_byteenable[k]);
                    end
                end
                CSO_A_FUNC_HI: begin
                    for (int k = 0; k < 2; k++) begin
                        func_r[k+4] <= merge8(func_r[k+4],
                            i_avs_writedata[k*8 +: 8], i_avs_byteenable[k]);
                    end
                end
                CSO_A_SRC: begin
                    if (i_avs_byteenable[0]) begin
                        frequency_source_select_r <= i_avs_writedata[2:0];
                        run_source_select_r       <= i_avs_writedata[5:4];
                    end
                    if (i_avs_byteenable[1]) begin
                        offset_direction_select_r <= i_avs_writedata[8];
                    end
                end
                CSO_A_FREQ: begin
                    if (&i_avs_byteenable[1:0]) begin
                        offset_frequency_value_r <= i_avs_writedata[15:0];
                    end
                    if (&i_avs_byteenable[3:2]) begin
                        max_freq_r <= i_avs_writedata[31:16];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // read data registered; unmapped reads return zero
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && !ack_r) begin
            case (i_avs_address)
                CSO_A_FUNC_LO: o_avs_readdata <=
                    {func_r[3], func_r[2], func_r[1], func_r[0]};
                CSO_A_FUNC_HI: o_avs_readdata <=
                    {8'h00, state_r == CSO_ST_STOP, 6'h00, keypad_r,
                     func_r[5], func_r[4]};
                CSO_A_SRC: o_avs_readdata <=
                    {23'h0, offset_direction_select_r, 2'h0,
                     run_source_select_r, 1'b0, frequency_source_select_r};
                CSO_A_FREQ: o_avs_readdata <=
                    {max_freq_r, offset_frequency_value_r};
                default: o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // a change of force state while driving holds the old sources
    // and commands a stop; the switch happens only once stopped
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_r  <= CSO_ST_IDLE;
            keypad_r <= 1'b0;
        end else begin
            case (state_r)
                CSO_ST_IDLE: begin
                    if (operator_force_input != keypad_r) begin
                        if (i_motor_driving) begin
                            state_r <= CSO_ST_STOP;
                        end else begin
                            keypad_r <= operator_force_input;
                        end
                    end
                end
                CSO_ST_STOP: begin
                    if (!i_motor_driving) begin
                        keypad_r <= operator_force_input;
                        state_r  <= CSO_ST_IDLE;
                    end
                end
                default: state_r <= CSO_ST_IDLE;
            endcase
        end
    end

    // source selection: keypad overrides while forced
    assign eff_fsrc = keypad_r ? CSO_SRC_KEYPAD
                               : frequency_source_select_r;

    always_comb begin
        case (eff_fsrc)
            3'h0:    base_freq = i_setpoints.src0;
            3'h1:    base_freq = i_setpoints.src1;
            3'h2:    base_freq = i_setpoints.src2;
            3'h3:    base_freq = i_setpoints.src3;
            3'h4:    base_freq = i_setpoints.src4;
            default: base_freq = CSO_ZERO_HZ;
        endcase
    end

    // run command: keypad acts at once while forced; stop overrides
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_run_cmd    <= '0;
            o_force_stop <= 1'b0;
        end else begin
            o_force_stop <= state_r == CSO_ST_STOP;
            if (state_r == CSO_ST_STOP) begin
                o_run_cmd <= '{start: 1'b0, stop: 1'b1};
            end else if (keypad_r ||
                         run_source_select_r == CSO_RUN_KEYPAD) begin
                o_run_cmd <= i_keypad_run;
            end else begin
                o_run_cmd <= i_ext_run;
            end
        end
    end

    assign o_keypad_active = keypad_r;

    // offset is combined every cycle with the live setpoint
    cso_offset_calc u_offset (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_base     (base_freq),
        .i_offset   (offset_frequency_value_r),
        .i_fmax     (max_freq_r),
        .i_apply    (offset_input),
        .i_subtract (offset_direction_select_r),
        .o_freq     (o_freq_cmd)
    );
endmodule
